// file: src/ums_pkg.sv
// shared constants and types for the serial port control block
// assumes a byte-wide special-function-register port with bit access
package ums_pkg;
  // ------------------------------------------------------------
  // register addresses and field positions
  // ------------------------------------------------------------
  localparam logic [7:0] UMS_SERIAL_PORT_CONTROL_ADDR  = 8'h98;
  localparam logic [7:0] UMS_SERIAL_DATA_BUFFER_ADDR  = 8'h99;
  localparam logic [7:0] UMS_SERIAL_PORT_CONTROL_RST   = 8'h00;
  localparam int         UMS_B_SM0_FE   = 7;
  localparam int         UMS_B_SM1      = 6;
  localparam int         UMS_B_SM2      = 5;
  localparam int         UMS_B_REN      = 4;
  localparam int         UMS_B_TB8      = 3;
  localparam int         UMS_B_RB8      = 2;
  localparam int         UMS_B_TI       = 1;
  localparam int         UMS_B_RI       = 0;
  // ------------------------------------------------------------
  // bit timing: 16 samples per bit, vote at samples 7, 8 and 9
  // ------------------------------------------------------------
  localparam logic [3:0] UMS_OVS_LAST   = 4'hf;
  localparam logic [3:0] UMS_SMP_A      = 4'h7;
  localparam logic [3:0] UMS_SMP_B      = 4'h8;
  localparam logic [3:0] UMS_SMP_C      = 4'h9;
  localparam logic [3:0] UMS_TX_LEN8    = 4'ha;
  localparam logic [3:0] UMS_TX_LEN9    = 4'hb;
  localparam logic [3:0] UMS_M0_LEN     = 4'h8;
  localparam logic [3:0] UMS_RX_STOP8   = 4'h9;
  localparam logic [3:0] UMS_RX_STOP9   = 4'ha;
  localparam int         UMS_FIFO_W     = 8;
  localparam int         UMS_FIFO_D     = 32;
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    UMS_M_SHIFT, UMS_M_UART8, UMS_M_UART9F, UMS_M_UART9T
  } ums_mode_t;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       bit_wr;
    logic [7:0] addr;
    logic [2:0] bit_idx;
    logic [7:0] wdata;
  } ums_sfr_req_t;
endpackage

// file: src/ums_serial_ctrl.sv
// serial port control: control register, transmitter, receiver, receive fifo
// assumes synchronous pin inputs and a timer overflow pulse from outside
// ------------------------------------------------------------
// receive buffer
// ------------------------------------------------------------
module ums_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0]  wp_q, rp_q;
  logic         push, pop;
  assign in_ready  = (wp_q - rp_q) != (AW+1)'(D);
  assign out_valid = wp_q != rp_q;
  assign out_data  = mem[rp_q[AW-1:0]];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wp_q[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop)  rp_q <= rp_q + 1'b1;
    end
  end
endmodule // ums_fifo

module ums_serial_ctrl
  import ums_pkg::*;
(
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rstn,
  // register port
  input  wire ums_pkg::ums_sfr_req_t sfr_req,
  output logic [7:0]                 sfr_rdata,
  // power control bits and baud source
  input  wire logic                  error_access_select,
  input  wire logic                  double_rate_select,
  input  wire logic                  timer_ovf_tick,
  // address recognition
  input  wire logic [7:0]            given_addr,
  input  wire logic [7:0]            addr_mask,
  // serial pins
  input  wire logic                  rxd_in,
  output logic                       rxd_out,
  output logic                       rxd_oe_n,
  output logic                       txd
);
  import ums_pkg::*;
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic ums_vote(input logic a, input logic b, input logic c);
    return (a & b) | (a & c) | (b & c);
  endfunction
  function automatic logic ums_addr_hit(input logic [7:0] d, input logic [7:0] ga,
                                        input logic [7:0] m);
    logic [7:0] bc;
    bc = ga | m;
    return (((d ^ ga) & m) == 8'h00) || (((d ^ bc) & bc) == 8'h00);
  endfunction

  logic       sm0_q, sm1_q, sm2_q, ren_q, tb8_q, rb8_q, ti_q, ri_q, fe_q;
  logic [7:0] sfr_rdata_q;
  logic       txd_q, rxd_out_q, rxd_oe_n_q;
  ums_mode_t  mode;
  logic       is9;
  logic [7:0] wmask, wval;
  logic       serial_port_control_wr, serial_data_buffer_wr, serial_data_buffer_rd;
  assign mode    = ums_mode_t'({sm0_q, sm1_q});
  assign is9     = sm0_q;
  assign serial_port_control_wr = (sfr_req.wr | sfr_req.bit_wr) && sfr_req.addr == UMS_SERIAL_PORT_CONTROL_ADDR;
  assign serial_data_buffer_wr = sfr_req.wr && sfr_req.addr == UMS_SERIAL_DATA_BUFFER_ADDR;
  assign serial_data_buffer_rd = sfr_req.rd && sfr_req.addr == UMS_SERIAL_DATA_BUFFER_ADDR;
  // bit access writes one bit, taken from wdata[0]
  assign wmask = sfr_req.bit_wr ? (8'h01 << sfr_req.bit_idx) : 8'hff;
  assign wval  = sfr_req.bit_wr ? {8{sfr_req.wdata[0]}} : sfr_req.wdata;

  // ------------------------------------------------------------
  // bit-rate ticks
  // ------------------------------------------------------------
  logic ph_q, half_q, os_src, os_tick;
  logic m0_step;
  assign os_src  = (mode == UMS_M_UART9F) ? 1'b1 : timer_ovf_tick;
  assign os_tick = os_src & (double_rate_select | half_q);
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ph_q   <= 1'b0;
      half_q <= 1'b0;
    end else begin
      ph_q <= ~ph_q;
      if (os_src) half_q <= ~half_q;
    end
  end
  // shift-mode steps wait for the shift clock to be low, so every bit gets a rising edge
  assign m0_step = ph_q && !txd_q;

  // ------------------------------------------------------------
  // receive fifo: full stalls the start of the next frame
  // ------------------------------------------------------------
  logic       fifo_in_ready, fifo_out_valid, rx_push;
  logic [7:0] fifo_out_data, rx_dat_q;
  logic [7:0] rx_word;
  ums_fifo #(.W(UMS_FIFO_W), .D(UMS_FIFO_D)) u_rx_fifo (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .in_valid  (rx_push),
    .in_ready  (fifo_in_ready),
    .in_data   (rx_word),
    .out_valid (fifo_out_valid),
    .out_ready (serial_data_buffer_rd),
    .out_data  (fifo_out_data)
  );

  // ------------------------------------------------------------
  // transmitter
  // ------------------------------------------------------------
  logic        tx_busy_q, ti_set;
  logic [10:0] tx_sh_q;
  logic [3:0]  tx_left_q, tx_cnt_q;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tx_busy_q <= 1'b0;
      tx_sh_q   <= '1;
      tx_left_q <= '0;
      tx_cnt_q  <= '0;
      ti_set    <= 1'b0;
    end else begin
      ti_set <= 1'b0;
      // a write while busy is dropped rather than corrupting the frame
      if (serial_data_buffer_wr && !tx_busy_q) begin
        tx_busy_q <= 1'b1;
        tx_cnt_q  <= '0;
        if (mode == UMS_M_SHIFT) begin
          tx_sh_q   <= {3'b111, sfr_req.wdata};
          tx_left_q <= UMS_M0_LEN;
        end else begin
          tx_sh_q   <= is9 ? {1'b1, tb8_q, sfr_req.wdata, 1'b0}
                           : {2'b11, sfr_req.wdata, 1'b0};
          tx_left_q <= is9 ? UMS_TX_LEN9 : UMS_TX_LEN8;
        end
      end else if (tx_busy_q && mode == UMS_M_SHIFT && m0_step) begin
        tx_sh_q   <= {1'b1, tx_sh_q[10:1]};
        tx_left_q <= tx_left_q - 4'h1;
        if (tx_left_q == 4'h1) begin
          tx_busy_q <= 1'b0;
          ti_set    <= 1'b1;
        end
      end else if (tx_busy_q && mode != UMS_M_SHIFT && os_tick) begin
        tx_cnt_q <= tx_cnt_q + 4'h1;
        if (tx_cnt_q == UMS_OVS_LAST) begin
          tx_sh_q   <= {1'b1, tx_sh_q[10:1]};
          tx_left_q <= tx_left_q - 4'h1;
          if (tx_left_q == 4'h2) ti_set <= 1'b1;
          if (tx_left_q == 4'h1) tx_busy_q <= 1'b0;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // receiver
  // ------------------------------------------------------------
  logic       rx_busy_q, rxd_prev_q, smp_a_q, smp_b_q, rx_n9_q, bitv;
  logic [3:0] rx_cnt_q, rx_idx_q, rx_stop_idx;
  logic       rx_start, rx_fin, rx_fin0, rx_accept, stop_ok, rx_tick;
  assign bitv        = ums_vote(smp_a_q, smp_b_q, rxd_in);
  assign rx_stop_idx = is9 ? UMS_RX_STOP9 : UMS_RX_STOP8;
  assign rx_tick     = rx_busy_q && mode != UMS_M_SHIFT && os_tick && rx_cnt_q == UMS_SMP_C;
  assign rx_fin      = rx_tick && rx_idx_q == rx_stop_idx;
  assign rx_fin0     = rx_busy_q && mode == UMS_M_SHIFT && m0_step && rx_idx_q == 4'h7;
  // the last shift-mode bit is pushed together with the shift that takes it
  assign rx_word     = rx_fin0 ? {rxd_in, rx_dat_q[7:1]} : rx_dat_q;
  assign stop_ok     = bitv;
  assign rx_start    = !rx_busy_q && ren_q && fifo_in_ready &&
                       (mode == UMS_M_SHIFT ? (!ri_q && !tx_busy_q)
                                            : (rxd_prev_q && !rxd_in));
  always_comb begin
    rx_accept = 1'b0;
    if (rx_fin0) begin
      rx_accept = 1'b1;
    end else if (rx_fin) begin
      if (!sm2_q) rx_accept = 1'b1;
      else if (!is9) rx_accept = stop_ok;
      else rx_accept = rx_n9_q && ums_addr_hit(rx_dat_q, given_addr, addr_mask);
    end
  end
  assign rx_push = rx_accept;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rx_busy_q  <= 1'b0;
      rxd_prev_q <= 1'b1;
      smp_a_q    <= 1'b1;
      smp_b_q    <= 1'b1;
      rx_n9_q    <= 1'b0;
      rx_cnt_q   <= '0;
      rx_idx_q   <= '0;
      rx_dat_q   <= '0;
    end else begin
      rxd_prev_q <= rxd_in;
      if (rx_start) begin
        rx_busy_q <= 1'b1;
        rx_cnt_q  <= '0;
        rx_idx_q  <= '0;
      end else if (rx_busy_q && mode == UMS_M_SHIFT) begin
        if (m0_step) begin
          rx_dat_q <= {rxd_in, rx_dat_q[7:1]};
          rx_idx_q <= rx_idx_q + 4'h1;
          if (rx_fin0) rx_busy_q <= 1'b0;
        end
      end else if (rx_busy_q && os_tick) begin
        rx_cnt_q <= rx_cnt_q + 4'h1;
        if (rx_cnt_q == UMS_SMP_A) smp_a_q <= rxd_in;
        if (rx_cnt_q == UMS_SMP_B) smp_b_q <= rxd_in;
        if (rx_tick) begin
          rx_idx_q <= rx_idx_q + 4'h1;
          // a start bit that votes high was noise: drop back to hunting
          if (rx_idx_q == 4'h0 && bitv) rx_busy_q <= 1'b0;
          if (rx_idx_q >= 4'h1 && rx_idx_q <= 4'h8) rx_dat_q <= {bitv, rx_dat_q[7:1]};
          if (rx_idx_q == 4'h9 && is9) rx_n9_q <= bitv;
          if (rx_fin) rx_busy_q <= 1'b0;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // control register; hardware sets win over software clears
  // ------------------------------------------------------------
  logic w7;
  assign w7 = serial_port_control_wr && wmask[UMS_B_SM0_FE];
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      {sm0_q, sm1_q, sm2_q, ren_q, tb8_q, rb8_q, ti_q, ri_q} <= UMS_SERIAL_PORT_CONTROL_RST;
      fe_q <= 1'b0;
    end else begin
      if (w7 && !error_access_select) sm0_q <= wval[UMS_B_SM0_FE];
      if (serial_port_control_wr && wmask[UMS_B_SM1]) sm1_q <= wval[UMS_B_SM1];
      if (serial_port_control_wr && wmask[UMS_B_SM2]) sm2_q <= wval[UMS_B_SM2];
      if (serial_port_control_wr && wmask[UMS_B_REN]) ren_q <= wval[UMS_B_REN];
      if (serial_port_control_wr && wmask[UMS_B_TB8]) tb8_q <= wval[UMS_B_TB8];
      if (rx_accept && !rx_fin0) rb8_q <= is9 ? rx_n9_q : stop_ok;
      else if (serial_port_control_wr && wmask[UMS_B_RB8]) rb8_q <= wval[UMS_B_RB8];
      if (ti_set) ti_q <= 1'b1;
      else if (serial_port_control_wr && wmask[UMS_B_TI]) ti_q <= wval[UMS_B_TI];
      if (rx_accept) ri_q <= 1'b1;
      else if (serial_port_control_wr && wmask[UMS_B_RI]) ri_q <= wval[UMS_B_RI];
      if (rx_fin && !stop_ok) fe_q <= 1'b1;
      else if (w7 && error_access_select) fe_q <= wval[UMS_B_SM0_FE];
    end
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sfr_rdata_q <= 8'h00;
    end else if (sfr_req.rd) begin
      if (sfr_req.addr == UMS_SERIAL_PORT_CONTROL_ADDR)
        sfr_rdata_q <= {error_access_select ? fe_q : sm0_q, sm1_q, sm2_q, ren_q,
                        tb8_q, rb8_q, ti_q, ri_q};
      else if (sfr_req.addr == UMS_SERIAL_DATA_BUFFER_ADDR)
        sfr_rdata_q <= fifo_out_valid ? fifo_out_data : 8'h00;
      else
        sfr_rdata_q <= 8'h00;
    end
  end

  // ------------------------------------------------------------
  // pins; shift mode drives the shift clock on txd
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      txd_q      <= 1'b1;
      rxd_out_q  <= 1'b1;
      rxd_oe_n_q <= 1'b1;
    end else if (mode == UMS_M_SHIFT) begin
      txd_q      <= (tx_busy_q || rx_busy_q) ? ph_q : 1'b1;
      rxd_out_q  <= tx_sh_q[0];
      rxd_oe_n_q <= !tx_busy_q;
    end else begin
      txd_q      <= tx_busy_q ? tx_sh_q[0] : 1'b1;
      rxd_out_q  <= 1'b1;
      rxd_oe_n_q <= 1'b1;
    end
  end
  assign txd       = txd_q;
  assign rxd_out   = rxd_out_q;
  assign rxd_oe_n  = rxd_oe_n_q;
  assign sfr_rdata = sfr_rdata_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  AST_FE_SET: assert property (rx_fin && !stop_ok |=> fe_q)
    else $error("framing error not flagged");
  AST_FE_SEL: assert property (rx_fin && !stop_ok && !error_access_select |=> fe_q)
    else $error("framing error lost with select low");
  AST_FE_STICKY: assert property (fe_q && !w7 |=> fe_q)
    else $error("framing error cleared by hardware");
  AST_MP_NINTH: assert property (rx_fin && is9 && sm2_q && !rx_n9_q |=> !$rose(ri_q))
    else $error("data frame raised receive flag under filter");
  AST_M1_STOP: assert property (rx_fin && !is9 && sm2_q && !stop_ok |=> !$rose(ri_q))
    else $error("bad stop raised receive flag");
  AST_RB8_LOAD: assert property (rx_fin && is9 && rx_accept |=> rb8_q == $past(rx_n9_q))
    else $error("ninth bit not stored");
  AST_TI_HOLD: assert property (ti_q && !(serial_port_control_wr && wmask[UMS_B_TI]) |=> ti_q)
    else $error("transmit done cleared by hardware");
  AST_REN_OFF: assert property (!ren_q |=> !$rose(rx_busy_q))
    else $error("reception started while disabled");
  AST_TX_GO: assert property (serial_data_buffer_wr && !tx_busy_q |=> tx_busy_q ##0 ti_q == $past(ti_q))
    else $error("buffer write did not start transmit");
  AST_M0_RI: assert property (rx_fin0 |=> ri_q)
    else $error("shift-mode receive did not set flag");
  AST_RD7: assert property (sfr_req.rd && sfr_req.addr == UMS_SERIAL_PORT_CONTROL_ADDR
                            |=> sfr_rdata[7] == $past(error_access_select ? fe_q : sm0_q))
    else $error("bit 7 read mismatch");
  COV_ADDR: cover property (rx_fin && is9 && sm2_q && rx_accept);
  COV_FE: cover property (rx_fin && !stop_ok);
  COV_M0_RX: cover property (rx_fin0);
  COV_TI: cover property ($rose(ti_q));
endmodule // ums_serial_ctrl

// file: sim/ums_node.sv
// remote serial node: sends frames on the receive pin, decodes the transmit pin
// assumes the bench sets bit_len, nine and shift_mode to match the block's mode
module ums_node (
  // clock
  input  wire logic ref_clk,
  // serial pins
  output logic      rxd_in,
  input  wire logic txd,
  input  wire logic rxd_out,
  input  wire logic rxd_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  int         bit_len    = 16;
  int         n_cap      = 0;
  int         sb         = 0;
  int         sh_left    = 0;
  bit         nine       = 1'b1;
  bit         shift_mode = 1'b0;
  logic [8:0] cap        = '0;
  logic [7:0] sh_q       = '0;
  // ------------------------------------------------------------
  // frame sender, the line idles high
  // ------------------------------------------------------------
  initial rxd_in = 1'b1;
  task automatic send_frame(input logic [8:0] d, input logic stop_v);
    @(negedge ref_clk);
    rxd_in = 1'b0;
    repeat (bit_len) @(negedge ref_clk);
    for (int i = 0; i < (nine ? 9 : 8); i++) begin
      rxd_in = d[i]; // lsb first; ninth bit one marks an address frame
      repeat (bit_len) @(negedge ref_clk);
    end
    rxd_in = stop_v;
    repeat (bit_len) @(negedge ref_clk);
    rxd_in = 1'b1;
  endtask
  // ------------------------------------------------------------
  // decoders
  // ------------------------------------------------------------
  // mid-bit sampling; the count only moves once the stop bit has begun
  always begin
    @(negedge txd);
    if (!shift_mode) begin
      repeat (bit_len / 2) @(posedge ref_clk);
      for (int i = 0; i < 9; i++) begin
        repeat (bit_len) @(posedge ref_clk);
        cap[i] = txd;
      end
      repeat (bit_len) @(posedge ref_clk);
      n_cap++;
    end
  end
  always @(posedge txd) begin
    if (shift_mode && !rxd_oe_n) begin
      cap = {1'b0, rxd_out, cap[7:1]};
      sb++;
      if (sb == 8) begin
        sb = 0;
        n_cap++;
      end
    end
  end
  // shift-mode reception: next bit is presented as the shift clock falls
  always @(negedge txd) begin
    if (shift_mode && rxd_oe_n && sh_left > 0) begin
      rxd_in = sh_q[0];
      sh_q = sh_q >> 1;
      sh_left--;
    end
  end
endmodule // ums_node

// file: sim/ums_serial_ctrl_tb.sv
// self-checking bench for the serial port control block with a reference model
// assumes the remote node model ums_node sits on the serial pins
module ums_serial_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ums_pkg::*;
  logic         ref_clk, rstn, sel, dbl, tick, rxd_in, rxd_out, rxd_oe_n, txd, m_sm2, m_ren;
  ums_sfr_req_t req;
  logic [7:0]   rdata, rv, dv, given_addr, amask;
  int           m_mode;
  int           failures = 0;
  int           n_compared = 0;
  logic [8:0]   q[$];
  logic [8:0]   ad_tab[4];
  logic [7:0]   tx_tab[4] = '{8'h88, 8'h80, 8'hc8, 8'h40};

  ums_serial_ctrl i_dut (
    .ref_clk(ref_clk), .rstn(rstn), .sfr_req(req), .sfr_rdata(rdata),
    .error_access_select(sel), .double_rate_select(dbl), .timer_ovf_tick(tick),
    .given_addr(given_addr), .addr_mask(amask), .rxd_in(rxd_in), .rxd_out(rxd_out),
    .rxd_oe_n(rxd_oe_n), .txd(txd));
  ums_node i_node (
    .ref_clk(ref_clk), .rxd_in(rxd_in), .txd(txd), .rxd_out(rxd_out), .rxd_oe_n(rxd_oe_n));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // ------------------------------------------------------------
  // checks, register port and reference model
  // ------------------------------------------------------------
  task automatic test_done();
    $display("comparisons %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input string w, input logic [8:0] e, input logic [8:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", w, e, g);
    end
  endtask
  // k is {wr, rd, bit_wr}; one idle cycle between requests
  task automatic bus(input logic [2:0] k, input logic [7:0] a, input logic [2:0] bi,
                     input logic [7:0] d);
    @(negedge ref_clk);
    req = {k, a, bi, d};
    @(negedge ref_clk);
    req = '0;
  endtask
  task automatic rd(input logic [7:0] a);
    bus(3'b010, a, 3'h0, 8'h00);
    rv = rdata;
  endtask
  task automatic chk_bit(input string w, input int idx, input logic e);
    rd(UMS_SERIAL_PORT_CONTROL_ADDR);
    check(w, 9'(e), 9'(rv[idx]));
  endtask
  task automatic setm(input logic [7:0] b);
    bus(3'b100, UMS_SERIAL_PORT_CONTROL_ADDR, 3'h0, b);
    m_mode = int'(b[7:6]);
    m_sm2 = b[5];
    m_ren = b[4];
    i_node.nine = b[7];
    i_node.shift_mode = (b[7:6] == 2'b00);
  endtask
  function automatic logic exp_accept(logic [8:0] d, logic stop);
    logic hit;
    logic [7:0] bc;
    bc = given_addr | amask;
    hit = (((d[7:0] ^ given_addr) & amask) == 8'h00) || (((d[7:0] ^ bc) & bc) == 8'h00);
    if (!m_ren) return 1'b0;
    if (m_mode == 1) return !m_sm2 || stop;
    return !m_sm2 || (d[8] && hit);
  endfunction
  task automatic rx_frame(input logic [8:0] d, input logic stop);
    logic acc;
    acc = exp_accept(d, stop);
    if (acc) q.push_back(d & 9'h0ff);
    i_node.send_frame(d, stop);
    repeat (4) @(negedge ref_clk);
    rd(UMS_SERIAL_PORT_CONTROL_ADDR);
    check("receive done", 9'(acc), 9'(rv[UMS_B_RI]));
    if (acc && !(m_mode == 1 && m_sm2))
      check("receive ninth", 9'(m_mode == 1 ? stop : d[8]), 9'(rv[UMS_B_RB8]));
    bus(3'b001, UMS_SERIAL_PORT_CONTROL_ADDR, 3'h0, 8'h00);
    if (acc) begin
      rd(UMS_SERIAL_DATA_BUFFER_ADDR);
      check("received byte", q.pop_front(), {1'b0, rv});
    end
  endtask
  task automatic tx_byte(input logic e9);
    int n0;
    n0 = i_node.n_cap;
    dv = 8'($urandom);
    bus(3'b100, UMS_SERIAL_DATA_BUFFER_ADDR, 3'h0, dv);
    chk_bit("transmit done", UMS_B_TI, 1'b0);
    for (int i = 0; i < 600 && i_node.n_cap == n0; i++) @(negedge ref_clk);
    check("sent frame", {e9, dv}, i_node.cap);
    chk_bit("transmit done", UMS_B_TI, 1'b1);
    repeat (100) @(negedge ref_clk);
    chk_bit("transmit done", UMS_B_TI, 1'b1);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    req = '0;
    rstn = 1'b0;
    sel = 1'b0;
    dbl = 1'b1;
    tick = 1'b0;
    given_addr = 8'h5b;
    amask = 8'hfe;
    void'($urandom(42402));
    repeat (3) @(negedge ref_clk);
    rstn = 1'b1;
    rd(UMS_SERIAL_PORT_CONTROL_ADDR);
    check("control reset", 9'(UMS_SERIAL_PORT_CONTROL_RST), {1'b0, rv});
    rd(8'h9a);
    check("unmapped", 9'h000, {1'b0, rv});
    bus(3'b100, UMS_SERIAL_PORT_CONTROL_ADDR, 3'h0, 8'ha5);
    bus(3'b001, UMS_SERIAL_PORT_CONTROL_ADDR, 3'h4, 8'h01);
    rd(UMS_SERIAL_PORT_CONTROL_ADDR);
    check("control bit write", 9'h0b5, {1'b0, rv});
    setm(8'h90);
    for (int i = 0; i < 6; i++) begin
      dbl = (i != 5);
      i_node.bit_len = dbl ? 16 : 32;
      rx_frame(9'($urandom), 1'b1);
    end
    dbl = 1'b1;
    i_node.bit_len = 16;
    setm(8'h80);
    rx_frame(9'($urandom), 1'b1);
    ad_tab = '{9'($urandom) & 9'h0ff, {1'b1, given_addr}, {1'b1, given_addr ^ 8'h01},
               {1'b1, given_addr | 8'h20}};
    tick = 1'b1;
    for (int i = 0; i < 8; i++) begin
      setm(i < 4 ? 8'hb0 : 8'hf0);
      rx_frame(ad_tab[i % 4], 1'b1);
    end
    setm(8'h50);
    rx_frame(9'($urandom), 1'b1);
    setm(8'h70);
    rx_frame(9'($urandom), 1'b0);
    chk_bit("mode bit zero", UMS_B_SM0_FE, 1'b0);
    sel = 1'b1;
    chk_bit("framing error", UMS_B_SM0_FE, 1'b1);
    sel = 1'b0;
    setm(8'h50);
    rx_frame(9'($urandom), 1'b1);
    sel = 1'b1;
    chk_bit("framing error", UMS_B_SM0_FE, 1'b1);
    bus(3'b001, UMS_SERIAL_PORT_CONTROL_ADDR, 3'h7, 8'h00);
    chk_bit("framing error", UMS_B_SM0_FE, 1'b0);
    sel = 1'b0;
    for (int i = 0; i < 4; i++) begin
      setm(tx_tab[i]);
      tx_byte(tx_tab[i][7] ? tx_tab[i][3] : 1'b1);
    end
    setm(8'h00);
    tx_byte(1'b0);
    dv = 8'($urandom);
    i_node.sh_q = dv;
    i_node.sh_left = 8;
    setm(8'h30);
    for (int i = 0; i < 40 && rv[UMS_B_RI] !== 1'b1; i++) rd(UMS_SERIAL_PORT_CONTROL_ADDR);
    check("shift receive done", 9'h001, 9'(rv[UMS_B_RI]));
    setm(8'h00);
    rd(UMS_SERIAL_DATA_BUFFER_ADDR);
    check("shift byte", {1'b0, dv}, {1'b0, rv});
    // fill the receive buffer past its depth, then drain it dry
    setm(8'h90);
    q.delete();
    for (int i = 0; i < 33; i++) begin
      dv = 8'($urandom);
      if (i < UMS_FIFO_D) q.push_back({1'b0, dv});
      i_node.send_frame({1'b0, dv}, 1'b1);
    end
    for (int i = 0; i < 33; i++) begin
      rd(UMS_SERIAL_DATA_BUFFER_ADDR);
      check("buffered byte", q.size() > 0 ? q.pop_front() : 9'h000, {1'b0, rv});
    end
    test_done();
  end
  // about five times the expected run length
  initial begin
    #200000;
    failures++;
    test_done();
  end
endmodule // ums_serial_ctrl_tb
